// *** rtl/flash_mode_pkg.sv ***
// Constants, types and the command decoder for the address-mode block
package flash_mode_pkg;

  // Quad-protocol mode-change opcodes with printed values; the wide-mode opcodes are module parameters
  localparam logic [7:0] OPC_ENTER_QUAD = 8'h35;
  localparam logic [7:0] OPC_LEAVE_QUAD = 8'hF5;

  // Values after power-up
  localparam logic [7:0] SEG_RESET = 8'h00;
  localparam logic WIDE_RESET = 1'h0;
  localparam logic QUAD_RESET = 1'h0;

  // Only segment bits 3..0 exist; bits 7..4 read as zero
  localparam logic [7:0] SEG_USED_MASK = 8'h0F;

  // Address phase lengths in bytes
  localparam logic [2:0] ADDR_BYTES_NARROW = 3'h3;
  localparam logic [2:0] ADDR_BYTES_WIDE = 3'h4;

  // Bits moved per clock edge and per byte
  localparam logic [3:0] STEP_SPI = 4'h1;
  localparam logic [3:0] STEP_QUAD = 4'h4;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Kind of array access handed to the memory core
  typedef enum logic [2:0] {
    KIND_NONE = 3'h0,
    KIND_READ = 3'h1,
    KIND_PROGRAM = 3'h2,
    KIND_SECTOR = 3'h3,
    KIND_BLOCK32 = 3'h4,
    KIND_BLOCK64 = 3'h5,
    KIND_CHIP = 3'h6
  } access_kind_type;

  // Link-side frame states, one-hot
  typedef enum logic [4:0] {
    ST_OPC = 5'h01,
    ST_ADDR = 5'h02,
    ST_DATA = 5'h04,
    ST_OUT = 5'h08,
    ST_IDLE = 5'h10
  } link_state_type;

  typedef struct packed {
    access_kind_type kind;
    logic always_wide;
  } cmd_info_type;

  // Classify an array opcode; the 4-byte set always takes 32 address bits
  function automatic cmd_info_type decode_array_cmd(input logic [7:0] opc);
    cmd_info_type info;
    info = '{kind: KIND_NONE, always_wide: 1'h0};
    case (opc)
      8'h03, 8'h0B, 8'hBB, 8'h3B, 8'hEB, 8'h6B: info.kind = KIND_READ;
      8'h02, 8'h38: info.kind = KIND_PROGRAM;
      8'h20: info.kind = KIND_SECTOR;
      8'h52: info.kind = KIND_BLOCK32;
      8'hD8: info.kind = KIND_BLOCK64;
      8'h60, 8'hC7: info.kind = KIND_CHIP;
      8'h13, 8'h0C, 8'hBC, 8'h3C, 8'hEC, 8'h6C:
        info = '{kind: KIND_READ, always_wide: 1'h1};
      8'h12, 8'h3E: info = '{kind: KIND_PROGRAM, always_wide: 1'h1};
      8'h21: info = '{kind: KIND_SECTOR, always_wide: 1'h1};
      8'h5C: info = '{kind: KIND_BLOCK32, always_wide: 1'h1};
      8'hDC: info = '{kind: KIND_BLOCK64, always_wide: 1'h1};
      default: info.kind = KIND_NONE;
    endcase
    return info;
  endfunction

endpackage

// *** rtl/drive_if.sv ***
// Signals from the frame decoder to the output driver
`timescale 1ns/1ps
interface drive_if;
  logic en;
  logic quad;
  logic [7:0] data;
  modport link (output en, output quad, output data);
  modport drv (input en, input quad, input data);
endinterface

// *** rtl/sync2.sv ***
// Two-flop level synchroniser
`timescale 1ns/1ps
module sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Levels in and out
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= RESET_VAL;
      q_o <= RESET_VAL;
    end
    else
    begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule

// *** rtl/shift_out_driver.sv ***
// Drives reply bits onto the I/O lines on falling link clock edges
`timescale 1ns/1ps
module shift_out_driver (
  // Link clock and select
  input wire logic sclk_i,
  input wire logic cs_n_i,
  // Reply source
  drive_if.drv drv,
  // Pin drive
  output logic [3:0] io_o,
  output logic [3:0] io_oe_o
);
  logic [2:0] pos_q;

  // Byte repeats so the host may stop after any bit
  always_ff @(negedge sclk_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      io_o <= 4'h0;
      io_oe_o <= 4'h0;
      pos_q <= 3'h0;
    end
    else if (drv.en)
    begin
      if (drv.quad)
      begin
        io_oe_o <= 4'hF;
        io_o <= pos_q[0] ? drv.data[3:0] : drv.data[7:4];
        pos_q <= {2'h0, ~pos_q[0]};
      end
      else
      begin
        io_oe_o <= 4'h2; // Single-line reply leaves on line 1
        io_o <= {2'h0, drv.data[3'h7 - pos_q], 1'h0};
        pos_q <= pos_q + 3'h1;
      end
    end
  end
endmodule

// *** rtl/flash_address_mode_control.sv ***
// Address-width, segment and quad-protocol control of the serial flash
`timescale 1ns/1ps
// What this block does
// R1: Enter-wide command sets flag, 32-bit addresses
// R2: Exit-wide command returns to 3-byte addresses
// R3: Low four segment bits pick 128Mb segment
// R4: 4-byte command set always takes 32 bits
// R5: Wide mode ignores the segment register
// R6: Segment register supplies A31..A24 for 3-byte
// R7: Upper four bits read zero; reset zero
// R8: 3-byte accesses act inside selected segment
// R9: Continuous read runs on, register unchanged
// R10: Read start address confined to segment
// R11: Chip erase covers the whole array
// R12: Erase and program stay inside segment
// R13: Opcode 35h enters quad command protocol
// R14: Quad protocol moves all phases four-wide
// R15: Opcode F5h returns to single-line commands
// R16: Host keeps select high before next
// R17: Mode changes need select rise on byte
// R18: Segment read streams data until select rises
// R19: Power-up: 3-byte, single-line, segment zero
// R20: Segment write loads byte, read returns it
module flash_address_mode_control #(
  parameter logic [7:0] ENTER_WIDE_OPC = 8'hB7,
  parameter logic [7:0] EXIT_WIDE_OPC = 8'hE9,
  parameter logic [7:0] SEG_WRITE_OPC = 8'hC5,
  parameter logic [7:0] SEG_READ_OPC = 8'hC8
) (
  // Core clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Serial link from the host
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic [3:0] io_i,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_o,
  // Array access request to the memory core
  output logic access_valid_o,
  output flash_mode_pkg::access_kind_type access_kind_o,
  output logic [31:0] access_addr_o,
  output logic access_confine_o,
  // Mode state
  output logic wide_address_flag_o,
  output logic quad_cmd_mode_o,
  output logic [7:0] segment_select_reg_o,
  output logic cmd_rejected_o
);

  // Mode state, core domain
  logic wide_q;
  logic quad_q;
  logic [7:0] seg_q;

  // Frame state, link domain, cleared while select is high
  flash_mode_pkg::link_state_type state_q;
  flash_mode_pkg::link_state_type state_d;
  logic [3:0] bit_pos_q;
  logic [7:0] sh_q;
  logic [23:0] addr_sh_q;
  logic [2:0] addr_left_q;
  logic first_q;
  flash_mode_pkg::cmd_info_type info_q;

  // Frame records, link domain, kept after select rises
  logic rec_frame_tgl_q;
  logic rec_req_tgl_q;
  logic rec_aligned_q;
  logic [7:0] rec_opc_q;
  logic [7:0] rec_data_q;
  logic rec_data_ok_q;
  logic rec_addr_ok_q;
  logic [31:0] rec_addr_q;
  flash_mode_pkg::access_kind_type rec_kind_q;
  logic rec_confine_q;

  // Link-side combinational terms
  logic [3:0] step;
  logic [3:0] pos_next;
  logic byte_done;
  logic [7:0] sh_next;
  logic [31:0] addr_next;
  logic [31:0] addr_full;
  logic wide_now;
  flash_mode_pkg::cmd_info_type opc_info;

  // Core-side crossing and commit terms
  logic [2:0] sync_q;
  logic cs_s;
  logic frame_s;
  logic req_s;
  logic cs_prev_q;
  logic frame_seen_q;
  logic req_seen_q;
  logic cs_rise;
  logic commit;
  logic is_mode;
  logic is_erase;
  flash_mode_pkg::cmd_info_type rec_info;

  drive_if drv_bus ();

  // R14: four-wide shifting in quad protocol
  assign step = quad_q ? flash_mode_pkg::STEP_QUAD :
                         flash_mode_pkg::STEP_SPI;
  assign sh_next = quad_q ? {sh_q[3:0], io_i} : {sh_q[6:0], io_i[0]};
  assign pos_next = bit_pos_q + step;
  assign byte_done = (pos_next == flash_mode_pkg::BITS_PER_BYTE);
  assign opc_info = flash_mode_pkg::decode_array_cmd(sh_next);
  assign addr_next = {addr_sh_q, sh_next};

  // R4: 4-byte set is wide regardless of mode
  assign wide_now = info_q.always_wide | wide_q;

  // R5: wide address bypasses segment register
  // R6: segment byte supplies A31..A24
  // R8: 3-byte addresses fall in selected segment
  // R10: random start never leaves the segment
  assign addr_full = wide_now ? addr_next :
    {seg_q & flash_mode_pkg::SEG_USED_MASK, addr_next[23:0]};

  // Next frame state once a byte completes
  always_comb
  begin
    state_d = state_q;
    if (byte_done)
    begin
      case (state_q)
        flash_mode_pkg::ST_OPC:
        begin
          if (opc_info.kind != flash_mode_pkg::KIND_NONE &&
              opc_info.kind != flash_mode_pkg::KIND_CHIP)
            state_d = flash_mode_pkg::ST_ADDR;
          else if (sh_next == SEG_WRITE_OPC)
            state_d = flash_mode_pkg::ST_DATA;
          else if (sh_next == SEG_READ_OPC)
            state_d = flash_mode_pkg::ST_OUT;
          else
            state_d = flash_mode_pkg::ST_IDLE;
        end
        flash_mode_pkg::ST_ADDR:
        begin
          if (addr_left_q == 3'h1)
            state_d = flash_mode_pkg::ST_IDLE;
        end
        flash_mode_pkg::ST_DATA:
          state_d = flash_mode_pkg::ST_IDLE;
        flash_mode_pkg::ST_OUT:
          state_d = flash_mode_pkg::ST_OUT;
        flash_mode_pkg::ST_IDLE:
          state_d = flash_mode_pkg::ST_IDLE;
        default:
          state_d = flash_mode_pkg::ST_IDLE;
      endcase
    end
  end

  // Frame state; select high clears it so each frame starts clean
  always_ff @(posedge sclk_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      state_q <= flash_mode_pkg::ST_OPC;
      bit_pos_q <= 4'h0;
      sh_q <= 8'h00;
      first_q <= 1'h1;
    end
    else
    begin
      state_q <= state_d;
      bit_pos_q <= byte_done ? 4'h0 : pos_next;
      sh_q <= sh_next;
      first_q <= 1'h0;
    end
  end

  // Address phase length is fixed by the opcode and mode
  always_ff @(posedge sclk_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      addr_left_q <= 3'h0;
      addr_sh_q <= 24'h000000;
      info_q <= '{kind: flash_mode_pkg::KIND_NONE, always_wide: 1'h0};
    end
    else if (byte_done)
    begin
      if (state_q == flash_mode_pkg::ST_OPC)
      begin
        info_q <= opc_info;
        // R1: wide flag lengthens every address phase
        // R2: cleared flag gives three address bytes to the 3-byte set
        addr_left_q <= (opc_info.always_wide | wide_q) ?
                       flash_mode_pkg::ADDR_BYTES_WIDE :
                       flash_mode_pkg::ADDR_BYTES_NARROW;
      end
      else if (state_q == flash_mode_pkg::ST_ADDR)
      begin
        addr_left_q <= addr_left_q - 3'h1;
        addr_sh_q <= addr_next[23:0];
      end
    end
  end

  // Records survive select rise; power reset gives them known values
  always_ff @(posedge sclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rec_frame_tgl_q <= 1'h0;
      rec_aligned_q <= 1'h0;
      rec_opc_q <= 8'h00;
      rec_data_ok_q <= 1'h0;
      rec_data_q <= 8'h00;
    end
    else
    begin
      if (first_q)
        rec_frame_tgl_q <= ~rec_frame_tgl_q;
      // R17: remember whether the last edge closed a byte
      rec_aligned_q <= byte_done;
      if (first_q || (byte_done && state_q == flash_mode_pkg::ST_OPC))
        rec_opc_q <= byte_done ? sh_next : 8'h00;
      if (byte_done && state_q == flash_mode_pkg::ST_DATA)
      begin
        rec_data_q <= sh_next;
        rec_data_ok_q <= 1'h1;
      end
      else if (first_q)
        rec_data_ok_q <= 1'h0;
    end
  end

  // Address capture and read or program hand-off
  always_ff @(posedge sclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rec_req_tgl_q <= 1'h0;
      rec_addr_ok_q <= 1'h0;
      rec_addr_q <= 32'h00000000;
      rec_kind_q <= flash_mode_pkg::KIND_NONE;
      rec_confine_q <= 1'h0;
    end
    else if (byte_done && state_q == flash_mode_pkg::ST_ADDR &&
             addr_left_q == 3'h1)
    begin
      rec_addr_q <= addr_full;
      rec_addr_ok_q <= 1'h1;
      rec_kind_q <= info_q.kind;
      // R12: narrow program and erase may not cross segments
      rec_confine_q <= ~wide_now;
      if (info_q.kind == flash_mode_pkg::KIND_READ ||
          info_q.kind == flash_mode_pkg::KIND_PROGRAM)
        rec_req_tgl_q <= ~rec_req_tgl_q;
    end
    else if (first_q)
      rec_addr_ok_q <= 1'h0;
  end

  // R18: reply runs while select stays low
  // R20: segment read returns the current value
  // R7: unused upper bits read back as zero
  assign drv_bus.en = (state_q == flash_mode_pkg::ST_OUT);
  assign drv_bus.quad = quad_q;
  assign drv_bus.data = seg_q & flash_mode_pkg::SEG_USED_MASK;

  shift_out_driver u_driver (
    .sclk_i(sclk_i),
    .cs_n_i(cs_n_i),
    .drv(drv_bus),
    .io_o(io_o),
    .io_oe_o(io_oe_o)
  );

  // Select level and both toggles cross into the core clock
  sync2 #(
    .WIDTH(3),
    .RESET_VAL(3'h4)
  ) u_sync (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .d_i({cs_n_i, rec_frame_tgl_q, rec_req_tgl_q}),
    .q_o(sync_q)
  );

  assign cs_s = sync_q[2];
  assign frame_s = sync_q[1];
  assign req_s = sync_q[0];
  assign cs_rise = cs_s & ~cs_prev_q;
  // A select pulse with no clock edge carries no new frame
  assign commit = cs_rise & (frame_s != frame_seen_q);
  assign rec_info = flash_mode_pkg::decode_array_cmd(rec_opc_q);
  assign is_mode = (rec_opc_q == ENTER_WIDE_OPC) ||
                   (rec_opc_q == EXIT_WIDE_OPC) ||
                   (rec_opc_q == flash_mode_pkg::OPC_ENTER_QUAD) ||
                   (rec_opc_q == flash_mode_pkg::OPC_LEAVE_QUAD);
  assign is_erase = (rec_info.kind == flash_mode_pkg::KIND_SECTOR) ||
                    (rec_info.kind == flash_mode_pkg::KIND_BLOCK32) ||
                    (rec_info.kind == flash_mode_pkg::KIND_BLOCK64) ||
                    (rec_info.kind == flash_mode_pkg::KIND_CHIP);

  // Edge and event bookkeeping
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      cs_prev_q <= 1'h1;
      frame_seen_q <= 1'h0;
      req_seen_q <= 1'h0;
    end
    else
    begin
      cs_prev_q <= cs_s;
      req_seen_q <= req_s;
      if (cs_rise)
        frame_seen_q <= frame_s;
    end
  end

  // Mode changes only while select is high, so the link sees them
  // settled; the host's select-high wait covers the commit latency
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      // R19: start narrow, single-line, segment zero
      wide_q <= flash_mode_pkg::WIDE_RESET;
      quad_q <= flash_mode_pkg::QUAD_RESET;
    end
    else if (commit && rec_aligned_q)
    begin
      // R1: enter-wide sets the flag
      if (rec_opc_q == ENTER_WIDE_OPC)
        wide_q <= 1'h1;
      // R2: exit-wide clears the flag
      if (rec_opc_q == EXIT_WIDE_OPC)
        wide_q <= 1'h0;
      // R13: enter quad protocol
      if (rec_opc_q == flash_mode_pkg::OPC_ENTER_QUAD)
        quad_q <= 1'h1;
      // R15: back to single-line commands
      if (rec_opc_q == flash_mode_pkg::OPC_LEAVE_QUAD)
        quad_q <= 1'h0;
    end
  end

  // Segment register
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      seg_q <= flash_mode_pkg::SEG_RESET;
    // R20: write loads from the data byte
    // R3: only the low nibble selects a segment
    else if (commit && rec_opc_q == SEG_WRITE_OPC && rec_data_ok_q)
      seg_q <= rec_data_q & flash_mode_pkg::SEG_USED_MASK;
  end

  // Access requests: reads and programs at address end, erase at close
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      access_valid_o <= 1'h0;
      access_kind_o <= flash_mode_pkg::KIND_NONE;
      access_addr_o <= 32'h00000000;
      access_confine_o <= 1'h0;
    end
    else if (req_s != req_seen_q)
    begin
      // R9: core counts on across segments, register untouched
      access_valid_o <= 1'h1;
      access_kind_o <= rec_kind_q;
      access_addr_o <= rec_addr_q;
      access_confine_o <= rec_confine_q &
        (rec_kind_q == flash_mode_pkg::KIND_PROGRAM);
    end
    // R17: erase only when select rose on a byte boundary
    else if (commit && rec_aligned_q && is_erase &&
             (rec_addr_ok_q ||
              rec_info.kind == flash_mode_pkg::KIND_CHIP))
    begin
      access_valid_o <= 1'h1;
      access_kind_o <= rec_info.kind;
      // R11: chip erase ignores the segment
      access_addr_o <= (rec_info.kind == flash_mode_pkg::KIND_CHIP) ?
                       32'h00000000 : rec_addr_q;
      access_confine_o <= (rec_info.kind != flash_mode_pkg::KIND_CHIP) &
                          rec_confine_q;
    end
    else
      access_valid_o <= 1'h0;
  end

  // R17: misaligned mode change or erase is dropped
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      cmd_rejected_o <= 1'h0;
    else
      cmd_rejected_o <= commit & ~rec_aligned_q & (is_mode | is_erase);
  end

  // Mode state is visible straight from its flops
  assign wide_address_flag_o = wide_q;
  assign quad_cmd_mode_o = quad_q;
  assign segment_select_reg_o = seg_q;

endmodule

// *** sim/flash_address_mode_control_checker.sv ***
// Concurrent checks on the ports of the address-mode block
`timescale 1ns/1ps
module flash_address_mode_control_checker (
  // Core clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Serial link
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic [3:0] io_i,
  input wire logic [3:0] io_o,
  input wire logic [3:0] io_oe_o,
  // Array request
  input wire logic access_valid_o,
  input wire flash_mode_pkg::access_kind_type access_kind_o,
  input wire logic [31:0] access_addr_o,
  input wire logic access_confine_o,
  // Mode state
  input wire logic wide_address_flag_o,
  input wire logic quad_cmd_mode_o,
  input wire logic [7:0] segment_select_reg_o,
  input wire logic cmd_rejected_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Request event seen by several checks; drop event seen by one
  sequence req_ev;
    access_valid_o;
  endsequence
  sequence drop_ev;
    cmd_rejected_o;
  endsequence

  // Reset is synchronous, so it is judged one edge later
  reset_values_a: assert property (disable iff (1'b0)
    !rst_n_i |=> !wide_address_flag_o && !quad_cmd_mode_o
      && segment_select_reg_o == 8'h00 && !access_valid_o)
    else $error("state not cleared by reset");
  seg_upper_a: assert property (segment_select_reg_o[7:4] == 4'h0)
    else $error("segment upper bits not zero");
  req_pulse_a: assert property (req_ev |=> !access_valid_o)
    else $error("request longer than one cycle");
  chip_erase_a: assert property (req_ev and access_kind_o ==
    flash_mode_pkg::KIND_CHIP |-> access_addr_o == 32'h0 && !access_confine_o)
    else $error("chip erase limited to a segment");
  read_free_a: assert property (req_ev and access_kind_o ==
    flash_mode_pkg::KIND_READ |-> !access_confine_o)
    else $error("read confined to a segment");
  wide_free_a: assert property (req_ev and wide_address_flag_o
    |-> !access_confine_o)
    else $error("wide access bounded by segment");
  confine_seg_a: assert property (req_ev and access_confine_o
    |-> access_addr_o[31:24] == segment_select_reg_o)
    else $error("narrow access outside segment");
  mode_select_a: assert property ($changed({wide_address_flag_o,
    quad_cmd_mode_o, segment_select_reg_o}) |-> cs_n_i)
    else $error("mode changed inside a frame");
  drop_pulse_a: assert property (drop_ev |->
    $stable(wide_address_flag_o) && $stable(quad_cmd_mode_o)
    ##1 !cmd_rejected_o)
    else $error("dropped command changed mode");
  quad_reply_a: assert property (io_oe_o == 4'hF |-> quad_cmd_mode_o)
    else $error("four-line reply outside quad mode");
  idle_drive_a: assert property (cs_n_i |-> io_oe_o == 4'h0)
    else $error("lines driven while deselected");
endmodule

bind flash_address_mode_control flash_address_mode_control_checker i_checker (
  .ref_clk_i, .rst_n_i, .sclk_i, .cs_n_i, .io_i, .io_o, .io_oe_o,
  .access_valid_o, .access_kind_o, .access_addr_o, .access_confine_o,
  .wide_address_flag_o, .quad_cmd_mode_o, .segment_select_reg_o,
  .cmd_rejected_o);

// *** sim/flash_host_model.sv ***
// Host serial controller model driving select, link clock and I/O lines
`timescale 1ns/1ps
module flash_host_model (
  // Link outputs
  output logic sclk_o,
  output logic cs_n_o,
  output logic [3:0] io_o,
  // Resolved line levels
  input wire logic [3:0] line_i
);
  logic quad_q;

  // Link clock idles low between frames
  initial
  begin
    sclk_o = 1'h0;
    cs_n_o = 1'h1;
    io_o = 4'hA;
    quad_q = 1'h0;
  end

  // Half-step offset keeps edges off the core clock grid
  task automatic frame(input logic [39:0] d, input int n, input int rd_cyc,
    output logic [7:0] rd);
    rd = 8'h00;
    #0.5;
    cs_n_o = 1'h0;
    for (int i = n; i > 0; i -= (quad_q ? 4 : 1))
    begin
      io_o = quad_q ? d[i-1 -: 4] : {~io_o[3:1], d[i-1]};
      #8.1 sclk_o = 1'h1;
      #15 sclk_o = 1'h0;
      #6.9;
    end
    // Lines released during the reply: drive a changing pattern
    for (int k = 0; k < rd_cyc; k++)
    begin
      io_o = ~io_o;
      #8.1;
      rd = quad_q ? {rd[3:0], line_i} : {rd[6:0], line_i[1]};
      sclk_o = 1'h1;
      #15 sclk_o = 1'h0;
      #6.9;
    end
    // select rises after the n bits and any reply, on a byte or not
    cs_n_o = 1'h1;
    io_o = ~io_o;
    if (n == 8 && d[7:0] == 8'h35)
      quad_q = 1'h1;
    if (n == 8 && d[7:0] == 8'hF5)
      quad_q = 1'h0;
    // select stays high well past the select-high time
    #100;
  endtask
endmodule

// *** sim/test_flash_address_mode_control.sv ***
// Self-checking bench for the address-mode block
`timescale 1ns/1ps
module test_flash_address_mode_control;
  logic ref_clk, rst_n, sclk, cs_n, valid, confine, wide, quad, rej;
  logic got_q, rej_q, cap_conf;
  logic [3:0] host_io, dev_io, dev_oe, line;
  logic [7:0] seg, rd;
  logic [31:0] addr, cap_addr;
  flash_mode_pkg::access_kind_type kind, cap_kind;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;

  // The wire level follows whoever enables its driver
  assign line = (dev_oe & dev_io) | (~dev_oe & host_io);

  flash_address_mode_control i_flash_address_mode_control (
    .ref_clk_i(ref_clk), .rst_n_i(rst_n), .sclk_i(sclk), .cs_n_i(cs_n),
    .io_i(line), .io_o(dev_io), .io_oe_o(dev_oe), .access_valid_o(valid),
    .access_kind_o(kind), .access_addr_o(addr),
    .access_confine_o(confine), .wide_address_flag_o(wide),
    .quad_cmd_mode_o(quad), .segment_select_reg_o(seg),
    .cmd_rejected_o(rej));
  flash_host_model i_flash_host_model (
    .sclk_o(sclk), .cs_n_o(cs_n), .io_o(host_io), .line_i(line));

  initial
  begin
    ref_clk = 1'h0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Pulses are caught here since they last one cycle; hang guard too
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (valid === 1'h1)
    begin
      got_q <= 1'h1;
      cap_kind <= kind;
      cap_addr <= addr;
      cap_conf <= confine;
    end
    if (rej === 1'h1)
      rej_q <= 1'h1;
    if (cyc == 20000)
    begin
      n_errors++;
      summarize();
    end
  end

  task automatic summarize();
    if (n_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Mode state after a frame, including the drop flag
  task automatic mode(input logic [39:0] d, input int n, input logic w,
    input logic q, input logic [7:0] s, input logic r);
    rej_q = 1'h0;
    i_flash_host_model.frame(d, n, 0, rd);
    check({21'h0, rej_q, wide, quad, seg}, {21'h0, r, w, q, s});
  endtask

  // One array request frame and the request it must raise
  task automatic req(input logic [39:0] d, input int n,
    input flash_mode_pkg::access_kind_type k, input logic [31:0] a,
    input logic c);
    got_q = 1'h0;
    i_flash_host_model.frame(d, n, 0, rd);
    check({27'h0, got_q, cap_kind, cap_conf}, {27'h0, 1'h1, k, c});
    check(cap_addr, a);
  endtask

  initial
  begin
    rst_n = 1'h0;
    got_q = 1'h0;
    rej_q = 1'h0;
    repeat (6) @(negedge ref_clk);
    rst_n = 1'h1;
    repeat (4) @(negedge ref_clk);
    check({18'h0, wide, quad, seg, dev_oe}, 32'h0);
    mode({8'hC5, 8'hA5}, 16, 1'h0, 1'h0, 8'h05, 1'h0);
    i_flash_host_model.frame(40'hC8, 8, 16, rd);
    check({24'h0, rd}, 32'h05);
    req({8'h03, 24'h123456}, 32, flash_mode_pkg::KIND_READ,
      32'h05123456, 1'h0);
    req({8'h20, 24'hFFF000}, 32, flash_mode_pkg::KIND_SECTOR,
      32'h05FFF000, 1'h1);
    req({8'hD8, 24'h010000}, 32, flash_mode_pkg::KIND_BLOCK64,
      32'h05010000, 1'h1);
    req(40'h60, 8, flash_mode_pkg::KIND_CHIP, 32'h0, 1'h0);
    // Select rising mid-byte: before any whole opcode, then after one
    mode(40'h5B, 7, 1'h0, 1'h0, 8'h05, 1'h0);
    mode(40'hB70, 12, 1'h0, 1'h0, 8'h05, 1'h1);
    mode(40'hB7, 8, 1'h1, 1'h0, 8'h05, 1'h0);
    req({8'h03, 32'h0A123456}, 40, flash_mode_pkg::KIND_READ,
      32'h0A123456, 1'h0);
    req({8'h20, 32'h0BFFF000}, 40, flash_mode_pkg::KIND_SECTOR,
      32'h0BFFF000, 1'h0);
    mode(40'hE9, 8, 1'h0, 1'h0, 8'h05, 1'h0);
    req({8'h02, 24'h000010}, 32, flash_mode_pkg::KIND_PROGRAM,
      32'h05000010, 1'h1);
    req({8'h21, 32'h0C000000}, 40, flash_mode_pkg::KIND_SECTOR,
      32'h0C000000, 1'h0);
    req({8'h12, 32'h0E0000F0}, 40, flash_mode_pkg::KIND_PROGRAM,
      32'h0E0000F0, 1'h0);
    mode(40'h35, 8, 1'h0, 1'h1, 8'h05, 1'h0);
    mode({8'hC5, 8'h3C}, 16, 1'h0, 1'h1, 8'h0C, 1'h0);
    i_flash_host_model.frame(40'hC8, 8, 2, rd);
    check({24'h0, rd}, 32'h0C);
    req({8'h03, 24'h000100}, 32, flash_mode_pkg::KIND_READ,
      32'h0C000100, 1'h0);
    req({8'h52, 24'h008000}, 32, flash_mode_pkg::KIND_BLOCK32,
      32'h0C008000, 1'h1);
    req(40'hC7, 8, flash_mode_pkg::KIND_CHIP, 32'h0, 1'h0);
    mode(40'hF5, 8, 1'h0, 1'h0, 8'h0C, 1'h0);
    summarize();
  end
endmodule
